// >>> src/srr_defines.vh
`ifndef SRR_DEFINES_VH
`define SRR_DEFINES_VH

// supply selection encoding
`define SRR_SUP_MAIN        1'h0
`define SRR_SUP_STBY        1'h1

// sequencer states
`define SRR_ST_RESET        2'h0
`define SRR_ST_FROZEN       2'h1
`define SRR_ST_RUN          2'h2

// power mode encoding
`define SRR_MODE_RUN        2'h0
`define SRR_MODE_IDLE       2'h1
`define SRR_MODE_PWRDN      2'h2
`define SRR_MODE_STBY       2'h3

// retained region size in kbytes
`define SRR_RET_KBYTES      16
// low-power oscillator rate in khz
`define SRR_LP_OSC_KHZ      32

// reset values
`define SRR_RST_ENABLE      1'h0
`define SRR_RST_FREEZE      1'h1

`endif

// >>> src/srr_retention_ctrl.v
`timescale 1ns/1ps
`include "srr_defines.vh"

// Functional notes
// - holding the device in reset disables the retained ram and freezes its interface.
// - clearing the retained ram enable freezes the ram interface in the same cycle.
// - a reset event switches the ram supply to the standby low-voltage supply.
// - the ram stays frozen until software sets the enable again; no power-on reset is needed in between.
// - while the core supply is below the standby reference the ram stays frozen unless the enable was already set when it fell.
// - a supply dip while the enable is set does not switch to standby and the ram stays usable.
// - write strobes from the core are blocked while power is falling so no false write occurs.
// - the low-voltage detector holds the device in reset until the core supply passes its threshold.
// - on reset release the still-frozen ram supply returns to the main core supply.
// - the real-time clock runs in standby only with the low-power 32 khz oscillator as reference.
// - idle stops the cpu, power-down stops cpu and peripherals, standby keeps retained ram and, on the low-power osc, the rtc.
// - standby is entered by removing the main supply while the device is held in reset.
module srr_retention_ctrl (
    // clock and reset
    input  wire       clk_sys_in,
    input  wire       rst_n_in,
    // supply monitors
    input  wire       core_supply_low_in,
    input  wire       low_voltage_detector_in,
    input  wire       main_supply_on_in,
    // software control
    input  wire       retained_ram_enable_wr_in,
    input  wire       retained_ram_enable_val_in,
    input  wire       idle_req_in,
    input  wire       pwrdn_req_in,
    input  wire       wake_in,
    // core ram strobes
    input  wire       core_wr_n_in,
    input  wire       core_rd_n_in,
    // rtc reference
    input  wire       rtc_use_lp_osc_in,
    // outputs
    output reg        ram_freeze_out,
    output reg        ram_supply_sel_out,
    output reg        ram_wr_n_out,
    output reg        ram_rd_n_out,
    output reg        retained_ram_enable_out,
    output reg        internal_reset_out,
    output reg        rtc_run_out,
    output reg        cpu_run_out,
    output reg        periph_run_out,
    output reg  [1:0] power_mode_out,
    output reg  [1:0] seq_state_out
);

    // sequencer states
    localparam [1:0] ST_RESET  = `SRR_ST_RESET;
    localparam [1:0] ST_FROZEN = `SRR_ST_FROZEN;
    localparam [1:0] ST_RUN    = `SRR_ST_RUN;

    // power modes
    localparam [1:0] MD_RUN    = `SRR_MODE_RUN;
    localparam [1:0] MD_IDLE   = `SRR_MODE_IDLE;
    localparam [1:0] MD_PWRDN  = `SRR_MODE_PWRDN;
    localparam [1:0] MD_STBY   = `SRR_MODE_STBY;

    // gated strobes: bit 0 write, bit 1 read
    localparam       NUM_STB   = 2;

    wire               in_reset;
    reg                enable_ff;
    reg                nxt_enable;
    reg                supply_low_ff;
    reg                nxt_supply_low;
    reg                nxt_freeze;
    reg  [1:0]         state_ff;
    reg  [1:0]         nxt_state;
    reg  [1:0]         mode_ff;
    reg  [1:0]         nxt_mode;
    reg                nxt_supply_sel;
    reg                nxt_rtc_run;
    wire [NUM_STB-1:0] core_stb_n;
    wire [NUM_STB-1:0] nxt_stb_n;

    // cpu runs in run mode only
    function mode_runs_cpu;
        input [1:0] md;
        begin
            mode_runs_cpu = (md == MD_RUN);
        end
    endfunction

    // peripherals run in run and idle
    function mode_runs_periph;
        input [1:0] md;
        begin
            mode_runs_periph = mode_runs_cpu(md) | (md == MD_IDLE);
        end
    endfunction

    // internal reset from pin or detector
    assign in_reset = ~rst_n_in | low_voltage_detector_in;

    // enable bit cleared in reset, written by software otherwise
    always @* begin
        nxt_enable = enable_ff;
        if (in_reset) begin
            nxt_enable = `SRR_RST_ENABLE;
        end else if (retained_ram_enable_wr_in) begin
            nxt_enable = retained_ram_enable_val_in;
        end
    end

    always @(posedge clk_sys_in) begin
        enable_ff <= nxt_enable;
    end

    // standby latch: supply low matters only once the enable is clear
    always @* begin
        nxt_supply_low = supply_low_ff;
        if (in_reset) begin
            nxt_supply_low = 1'h0;
        end else if (core_supply_low_in && !enable_ff) begin
            nxt_supply_low = 1'h1;
        end else if (!core_supply_low_in) begin
            nxt_supply_low = 1'h0;
        end
    end

    always @(posedge clk_sys_in) begin
        supply_low_ff <= nxt_supply_low;
    end

    // freeze from next enable so a clear acts at once
    always @* begin
        nxt_freeze = 1'h0;
        if (in_reset) begin
            nxt_freeze = `SRR_RST_FREEZE;
        end else if (!nxt_enable) begin
            nxt_freeze = 1'h1;
        end else if (core_supply_low_in && !enable_ff) begin
            nxt_freeze = 1'h1;
        end else if (supply_low_ff) begin
            nxt_freeze = 1'h1;
        end
    end

    // retention sequencer
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RESET: begin
                if (!in_reset) begin
                    nxt_state = ST_FROZEN;
                end
            end
            ST_FROZEN: begin
                if (in_reset) begin
                    nxt_state = ST_RESET;
                end else if (!nxt_freeze) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (in_reset) begin
                    nxt_state = ST_RESET;
                end else if (nxt_freeze) begin
                    nxt_state = ST_FROZEN;
                end
            end
            default: begin
                nxt_state = ST_RESET;
            end
        endcase
    end

    always @(posedge clk_sys_in) begin
        state_ff <= nxt_state;
    end

    // power mode machine
    always @* begin
        nxt_mode = mode_ff;
        case (mode_ff)
            MD_RUN: begin
                if (idle_req_in) begin
                    nxt_mode = MD_IDLE;
                end else if (pwrdn_req_in) begin
                    nxt_mode = MD_PWRDN;
                end
            end
            MD_IDLE: begin
                if (wake_in) begin
                    nxt_mode = MD_RUN;
                end
            end
            MD_PWRDN: begin
                if (wake_in) begin
                    nxt_mode = MD_RUN;
                end
            end
            MD_STBY: begin
                if (main_supply_on_in) begin
                    nxt_mode = MD_RUN;
                end
            end
            default: begin
                nxt_mode = MD_RUN;
            end
        endcase
        if (in_reset && !main_supply_on_in) begin
            nxt_mode = MD_STBY;
        end else if (in_reset) begin
            nxt_mode = MD_RUN;
        end
    end

    always @(posedge clk_sys_in) begin
        mode_ff <= nxt_mode;
    end

    // standby supply in reset, main once released
    always @* begin
        nxt_supply_sel = `SRR_SUP_MAIN;
        if (in_reset) begin
            nxt_supply_sel = `SRR_SUP_STBY;
        end else begin
            nxt_supply_sel = `SRR_SUP_MAIN;
        end
    end

    // rtc keeps counting without main supply only on low-power osc
    always @* begin
        nxt_rtc_run = 1'h0;
        if (main_supply_on_in) begin
            nxt_rtc_run = 1'h1;
        end else if (rtc_use_lp_osc_in) begin
            nxt_rtc_run = 1'h1;
        end
    end

    // strobes forced inactive whenever frozen
    assign core_stb_n = {core_rd_n_in, core_wr_n_in};

    genvar g;
    generate
        for (g = 0; g < NUM_STB; g = g + 1) begin : g_stb
            assign nxt_stb_n[g] = nxt_freeze | core_stb_n[g];
        end
    endgenerate

    // registered control outputs
    always @(posedge clk_sys_in) begin
        retained_ram_enable_out <= nxt_enable;
        ram_freeze_out          <= nxt_freeze;
        internal_reset_out      <= in_reset;
        seq_state_out           <= nxt_state;
        power_mode_out          <= nxt_mode;
        ram_supply_sel_out      <= nxt_supply_sel;
    end

    // registered ram strobes
    always @(posedge clk_sys_in) begin
        ram_wr_n_out <= nxt_stb_n[0];
        ram_rd_n_out <= nxt_stb_n[1];
    end

    // registered run levels
    always @(posedge clk_sys_in) begin
        rtc_run_out    <= nxt_rtc_run;
        cpu_run_out    <= ~in_reset & mode_runs_cpu(nxt_mode);
        periph_run_out <= ~in_reset & mode_runs_periph(nxt_mode);
    end

endmodule

// >>> tb/srr_supply_model.sv
`timescale 1ns/1ps
module srr_supply_model (
    input  wire logic clk_sys_in,
    input  wire logic pwr_on_in,
    input  wire logic dip_in,
    output logic      rst_n_out = 0,
    output logic      lvd_out = 1,
    output logic      main_on_out = 0,
    output logic      core_low_out = 1
);
    logic rst_q = 0;
    // detector leads the pin so the pin stays low across both ramps
    always @(posedge clk_sys_in) begin
        main_on_out <= pwr_on_in;
        lvd_out <= !pwr_on_in;
        core_low_out <= !pwr_on_in || dip_in;
        rst_q <= main_on_out && !lvd_out;
        // pin drops with the supply so it never stands high on a falling rail
        rst_n_out <= rst_q && pwr_on_in;
    end
endmodule

// >>> tb/srr_props.sv
`timescale 1ns/1ps
module srr_props (
    input wire logic clk_sys_in, rst_n_in, core_supply_low_in, low_voltage_detector_in,
    input wire logic retained_ram_enable_wr_in, retained_ram_enable_val_in,
    input wire logic ram_freeze_out, ram_supply_sel_out, ram_wr_n_out, ram_rd_n_out,
    input wire logic retained_ram_enable_out, internal_reset_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    wire f = ram_freeze_out;
    wire e = retained_ram_enable_out;
    wire d = low_voltage_detector_in;
    wire l = core_supply_low_in;
    wire w = retained_ram_enable_wr_in;
    wire v = retained_ram_enable_val_in;
    sequence s_rel; $rose(rst_n_in) && !d; endsequence
    property p_rst; s_rel |-> f && ram_supply_sel_out && !e; endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_rel; s_rel |=> !ram_supply_sel_out && !internal_reset_out && f; endproperty
    a_rel: assert property (p_rel) else $error("bad release state");
    property p_lvd; d |=> internal_reset_out && f; endproperty
    a_lvd: assert property (p_lvd) else $error("detector ignored");
    property p_clr; w && !v |=> f; endproperty
    a_clr: assert property (p_clr) else $error("clear not frozen");
    property p_hold; !e && !(w && v) |=> f; endproperty
    a_hold: assert property (p_hold) else $error("unfrozen unset");
    property p_set; w && v && !l && !$past(l) && !d |=> e && !f; endproperty
    a_set: assert property (p_set) else $error("set not taken");
    property p_low; l && (f || !e) |=> f; endproperty
    a_low: assert property (p_low) else $error("low not frozen");
    property p_dip; l && e && !f && !w && !d |=> !f; endproperty
    a_dip: assert property (p_dip) else $error("dip froze");
    property p_gate; f |-> ram_wr_n_out && ram_rd_n_out; endproperty
    a_gate: assert property (p_gate) else $error("strobe leak");
endmodule
bind srr_retention_ctrl srr_props srr_props_inst (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .core_supply_low_in(core_supply_low_in),
    .low_voltage_detector_in(low_voltage_detector_in),
    .retained_ram_enable_wr_in(retained_ram_enable_wr_in),
    .retained_ram_enable_val_in(retained_ram_enable_val_in),
    .ram_freeze_out(ram_freeze_out), .ram_supply_sel_out(ram_supply_sel_out),
    .ram_wr_n_out(ram_wr_n_out), .ram_rd_n_out(ram_rd_n_out),
    .retained_ram_enable_out(retained_ram_enable_out),
    .internal_reset_out(internal_reset_out));

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk_sys_in = 0, pwr_on = 0, dip = 0, core_wr_n_in = 1, core_rd_n_in = 1;
    logic rst_n_in, core_supply_low_in, low_voltage_detector_in, main_supply_on_in;
    logic retained_ram_enable_wr_in = 0, retained_ram_enable_val_in = 0, idle_req_in = 0;
    logic pwrdn_req_in = 0, wake_in = 0, rtc_use_lp_osc_in = 1;
    logic ram_freeze_out, ram_supply_sel_out, ram_wr_n_out, ram_rd_n_out;
    logic retained_ram_enable_out, internal_reset_out, rtc_run_out, cpu_run_out;
    logic periph_run_out;
    logic [1:0] power_mode_out, seq_state_out;
    int err_count = 0, num_checks = 0, cycles = 0;
    srr_supply_model srr_supply_model_inst (.clk_sys_in(clk_sys_in), .pwr_on_in(pwr_on),
        .dip_in(dip), .rst_n_out(rst_n_in), .lvd_out(low_voltage_detector_in),
        .main_on_out(main_supply_on_in), .core_low_out(core_supply_low_in));
    srr_retention_ctrl srr_retention_ctrl_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .core_supply_low_in(core_supply_low_in), .low_voltage_detector_in(low_voltage_detector_in),
        .main_supply_on_in(main_supply_on_in),
        .retained_ram_enable_wr_in(retained_ram_enable_wr_in),
        .retained_ram_enable_val_in(retained_ram_enable_val_in), .idle_req_in(idle_req_in),
        .pwrdn_req_in(pwrdn_req_in), .wake_in(wake_in), .core_wr_n_in(core_wr_n_in),
        .core_rd_n_in(core_rd_n_in), .rtc_use_lp_osc_in(rtc_use_lp_osc_in),
        .ram_freeze_out(ram_freeze_out), .ram_supply_sel_out(ram_supply_sel_out),
        .ram_wr_n_out(ram_wr_n_out), .ram_rd_n_out(ram_rd_n_out),
        .retained_ram_enable_out(retained_ram_enable_out),
        .internal_reset_out(internal_reset_out), .rtc_run_out(rtc_run_out),
        .cpu_run_out(cpu_run_out), .periph_run_out(periph_run_out),
        .power_mode_out(power_mode_out), .seq_state_out(seq_state_out));
    initial begin
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    task chk(input string n, input logic [1:0] s, input logic [1:0] x);
        num_checks++;
        if (s !== x) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", n, x, s);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            err_count++;
            final_report();
        end
    end
    task cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task wr_en(input logic v);
        @(posedge clk_sys_in);
        retained_ram_enable_wr_in <= 1;
        retained_ram_enable_val_in <= v;
        @(posedge clk_sys_in);
        retained_ram_enable_wr_in <= 0;
        #1;
    endtask
    task t_power_on;
        @(posedge clk_sys_in);
        pwr_on <= 1;
        cyc(5);
        chk("sel", ram_supply_sel_out, 0);
        chk("frz", ram_freeze_out, 1);
        chk("state", seq_state_out, 2'h1);
        chk("irst", internal_reset_out, 0);
        chk("en", retained_ram_enable_out, 0);
    endtask
    task t_modes;
        @(posedge clk_sys_in);
        idle_req_in <= 1;
        @(posedge clk_sys_in);
        idle_req_in <= 0;
        wake_in <= 1;
        #1;
        chk("mode", power_mode_out, 2'h1);
        chk("cpu", cpu_run_out, 0);
        chk("per", periph_run_out, 1);
        @(posedge clk_sys_in);
        wake_in <= 0;
        pwrdn_req_in <= 1;
        #1;
        chk("mode", power_mode_out, 2'h0);
        chk("cpu", cpu_run_out, 1);
        @(posedge clk_sys_in);
        pwrdn_req_in <= 0;
        wake_in <= 1;
        #1;
        chk("mode", power_mode_out, 2'h2);
        chk("per", periph_run_out, 0);
        @(posedge clk_sys_in);
        wake_in <= 0;
        #1;
        chk("mode", power_mode_out, 2'h0);
        chk("per", periph_run_out, 1);
    endtask
    task t_standby;
        @(posedge clk_sys_in);
        pwr_on <= 0;
        cyc(5);
        chk("frz", ram_freeze_out, 1);
        chk("sel", ram_supply_sel_out, 1);
        chk("mode", power_mode_out, 2'h3);
        chk("irst", internal_reset_out, 1);
        chk("cpu", cpu_run_out, 0);
        chk("rtc", rtc_run_out, 1);
        @(posedge clk_sys_in);
        rtc_use_lp_osc_in <= 0;
        cyc(2);
        chk("rtc", rtc_run_out, 0);
        @(posedge clk_sys_in);
        rtc_use_lp_osc_in <= 1;
        t_power_on();
    endtask
    task t_enable;
        wr_en(1);
        chk("frz", ram_freeze_out, 0);
        @(posedge clk_sys_in);
        core_wr_n_in <= 0;
        core_rd_n_in <= 0;
        cyc(2);
        chk("wr", ram_wr_n_out, 0);
        chk("rd", ram_rd_n_out, 0);
        wr_en(0);
        chk("frz", ram_freeze_out, 1);
        chk("wr", ram_wr_n_out, 1);
        cyc(1);
        chk("rd", ram_rd_n_out, 1);
        @(posedge clk_sys_in);
        core_wr_n_in <= 1;
        core_rd_n_in <= 1;
    endtask
    task t_dip;
        wr_en(1);
        @(posedge clk_sys_in);
        dip <= 1;
        cyc(3);
        chk("frz", ram_freeze_out, 0);
        wr_en(0);
        wr_en(1);
        chk("frz", ram_freeze_out, 1);
        @(posedge clk_sys_in);
        dip <= 0;
        cyc(3);
        chk("frz", ram_freeze_out, 0);
    endtask
    initial begin
        cyc(20);
        t_power_on();
        t_enable();
        t_modes();
        t_dip();
        t_standby();
        t_enable();
        final_report();
    end
endmodule
